/* File: mode_debug_pkg.sv */
// Purpose: Shared constants for the mode selection and debug entry block.
// Assumes: 100 MHz core clock, 32-bit APB data, 12-bit APB byte address.
// Notes: Serial command codes and bit timing are local conventions.
package mode_debug_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ONE_LOW_MAX_NS = 160;
   localparam int ONE_LOW_MAX_CYC = ONE_LOW_MAX_NS / CLK_PERIOD_NS;
   localparam int IDLE_NS = 2560;
   localparam int IDLE_CYC = IDLE_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 10;
   localparam logic [2:0] LAST_BIT = 3'h7;

   localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hdffe;
   localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hdfff;

   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_PORTA = 12'h004;
   localparam logic [11:0] ADDR_PORTB = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00c;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   localparam int CTRL_LF_EN = 0;
   localparam int CTRL_PA4_OUT = 1;
   localparam int PA_DIR_LSB = 0;
   localparam int PA_OUT_LSB = 4;
   localparam int PA_PULL_EN_LSB = 8;
   localparam int PA_PULL_DN_LSB = 12;
   localparam int PA_WAKE_LSB = 16;
   localparam int PA_ADC_LSB = 20;
   localparam int PA_TMR_LSB = 22;
   localparam int PB_DIR_LSB = 0;
   localparam int PB_OUT_LSB = 2;
   localparam int PB_PU_LSB = 4;
   localparam int ST_DEBUG = 0;
   localparam int ST_RUN = 1;
   localparam int ST_PA_LSB = 2;
   localparam int ST_PB_LSB = 6;

   localparam int DSC_ENABLE = 7;
   localparam int DSC_ACTIVE = 6;
   localparam logic [7:0] DSC_RESET = 8'h80;

   localparam logic [7:0] CMD_BACKGROUND = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'he4;
   localparam logic [7:0] CMD_WRITE_CONTROL = 8'hc4;
   localparam logic [7:0] CMD_READ_BYTE = 8'he0;
   localparam logic [7:0] CMD_READ_BYTE_WS = 8'he1;
   localparam logic [7:0] CMD_WRITE_BYTE = 8'hc0;
   localparam logic [7:0] CMD_WRITE_BYTE_WS = 8'hc1;
   localparam logic [7:0] CMD_READ_DREG = 8'he8;
   localparam logic [7:0] CMD_WRITE_DREG = 8'hc8;
   localparam logic [7:0] CMD_READ_CPU = 8'h68;
   localparam logic [7:0] CMD_WRITE_CPU = 8'h48;
   localparam logic [7:0] CMD_TRACE1 = 8'h10;
   localparam logic [7:0] CMD_GO = 8'h08;

   typedef enum logic [5:0] {
      S_DECIDE = 6'b00_0001,
      S_FETCH_HI = 6'b00_0010,
      S_FETCH_LO = 6'b00_0100,
      S_LOAD = 6'b00_1000,
      S_RUN = 6'b01_0000,
      S_DEBUG = 6'b10_0000
   } mode_state_type;
endpackage : mode_debug_pkg

/* File: mode_debug_ifs.sv */
// Purpose: Internal carriers between the mode block and its helpers.
// Assumes: All ends run on core_clk_i.
// Notes: Top-level ports stay plain; these are internal only.
`timescale 1ns/1ps
interface rx_byte_if;
   logic [7:0] data;
   logic valid;
   modport src (output data, output valid);
   modport dst (input data, input valid);
endinterface : rx_byte_if

interface pin_cfg_if;
   logic lf_en;
   logic [3:0] pa_dir;
   logic [3:0] pa_out;
   logic [3:0] pa_pull_en;
   logic [3:0] pa_pull_dn;
   logic [3:0] pa_wake;
   logic [1:0] adc_sel;
   logic [1:0] tmr_sel;
   logic [1:0] pb_dir;
   logic [1:0] pb_out;
   logic [1:0] pb_pu;
   logic [3:0] pa_in;
   logic [1:0] pb_in;
   modport cfg (output lf_en, pa_dir, pa_out, pa_pull_en, pa_pull_dn, pa_wake, adc_sel, tmr_sel,
                output pb_dir, pb_out, pb_pu, input pa_in, pb_in);
   modport mux (input lf_en, pa_dir, pa_out, pa_pull_en, pa_pull_dn, pa_wake, adc_sel, tmr_sel,
                input pb_dir, pb_out, pb_pu, output pa_in, pb_in);
endinterface : pin_cfg_if

/* File: debug_rx.sv */
// Purpose: Receives serial command bytes from the synchronised debug pin.
// Assumes: A short low pulse is a one, a long low pulse a zero, MSB first.
// Notes: A long idle high time discards a partial byte.
`timescale 1ns/1ps
module debug_rx
   import mode_debug_pkg::*;
#(
   parameter int ONE_MAX = ONE_LOW_MAX_CYC,
   parameter int IDLE_MAX = IDLE_CYC
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Pin level and gate
   input wire logic pin_level_i,
   input wire logic listen_i,
   // Received bytes
   rx_byte_if.src rx
);
   import mode_debug_pkg::*;

   logic pin_d_reg;
   logic [CNT_W-1:0] low_cnt_reg;
   logic [CNT_W-1:0] high_cnt_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] data_reg;
   logic valid_reg;
   logic bit_next;

   assign bit_next = (low_cnt_reg <= CNT_W'(ONE_MAX));
   assign rx.data = data_reg;
   assign rx.valid = valid_reg;

   always_ff @(posedge core_clk_i) begin
      valid_reg <= 1'b0;
      if (sys_rst_i || !listen_i) begin
         pin_d_reg <= 1'b1;
         low_cnt_reg <= '0;
         high_cnt_reg <= '0;
         bit_cnt_reg <= '0;
         shift_reg <= '0;
         data_reg <= '0;
      end else begin
         pin_d_reg <= pin_level_i;
         if (!pin_level_i) begin
            high_cnt_reg <= '0;
            if (low_cnt_reg != '1) begin
               low_cnt_reg <= low_cnt_reg + 1'b1;
            end
         end else if (high_cnt_reg != CNT_W'(IDLE_MAX)) begin
            high_cnt_reg <= high_cnt_reg + 1'b1;
         end
         if (pin_level_i && !pin_d_reg) begin
            low_cnt_reg <= '0;
            shift_reg <= {shift_reg[6:0], bit_next};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == LAST_BIT) begin
               data_reg <= {shift_reg[6:0], bit_next};
               valid_reg <= 1'b1;
            end
         end else if (high_cnt_reg == CNT_W'(IDLE_MAX)) begin
            bit_cnt_reg <= '0;
         end
      end
   end
endmodule : debug_rx

/* File: pin_mux.sv */
// Purpose: Pin ownership for port A, port B and the low frequency inputs.
// Assumes: Pin inputs are asynchronous and pass two flip-flops here.
// Notes: A selected peripheral function releases the pin driver.
`timescale 1ns/1ps
module pin_mux (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Configuration
   pin_cfg_if.mux cfg,
   // Pins
   input wire logic [3:0] pa_i,
   input wire logic [1:0] pb_i,
   input wire logic lf_a_i,
   input wire logic lf_b_i,
   output logic [3:0] pa_o,
   output logic [3:0] pa_oe_o,
   output logic [3:0] pa_pu_o,
   output logic [3:0] pa_pd_o,
   output logic [3:0] kbi_o,
   output logic [1:0] adc_ch_o,
   output logic [1:0] tmr_ch_o,
   output logic [1:0] pb_o,
   output logic [1:0] pb_oe_o,
   output logic [1:0] pb_pu_o,
   output logic lf_a_o,
   output logic lf_b_o
);
   logic [3:0] pa_s1_reg;
   logic [3:0] pa_s2_reg;
   logic [1:0] pb_s1_reg;
   logic [1:0] pb_s2_reg;
   logic [1:0] lf_s1_reg;
   logic [1:0] lf_s2_reg;
   logic [3:0] func_sel;

   assign func_sel = {cfg.tmr_sel, cfg.adc_sel};
   assign cfg.pa_in = pa_s2_reg;
   assign cfg.pb_in = pb_s2_reg;

   always_ff @(posedge core_clk_i) begin
      pa_s1_reg <= pa_i;
      pa_s2_reg <= pa_s1_reg;
      pb_s1_reg <= pb_i;
      pb_s2_reg <= pb_s1_reg;
      lf_s1_reg <= {lf_b_i, lf_a_i};
      lf_s2_reg <= lf_s1_reg;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pa_o <= '0;
         pa_oe_o <= '0;
         pa_pu_o <= '0;
         pa_pd_o <= '0;
         kbi_o <= '0;
         adc_ch_o <= '0;
         tmr_ch_o <= '0;
      end else begin
         pa_o <= cfg.pa_out;
         pa_oe_o <= cfg.pa_dir & ~func_sel;
         pa_pu_o <= cfg.pa_pull_en & ~cfg.pa_pull_dn;
         pa_pd_o <= cfg.pa_pull_en & cfg.pa_pull_dn & cfg.pa_wake;
         kbi_o <= pa_s2_reg & cfg.pa_wake;
         adc_ch_o <= pa_s2_reg[1:0] & cfg.adc_sel;
         tmr_ch_o <= pa_s2_reg[3:2] & cfg.tmr_sel;
      end
   end

   // While the receiver owns the coil pins, port B must not load them.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pb_o <= '0;
         pb_oe_o <= '0;
         pb_pu_o <= '0;
         lf_a_o <= 1'b0;
         lf_b_o <= 1'b0;
      end else begin
         pb_o <= cfg.pb_out;
         pb_oe_o <= cfg.lf_en ? 2'h0 : cfg.pb_dir;
         pb_pu_o <= cfg.lf_en ? 2'h0 : cfg.pb_pu;
         lf_a_o <= cfg.lf_en & lf_s2_reg[0];
         lf_b_o <= cfg.lf_en & lf_s2_reg[1];
      end
   end
endmodule : pin_mux

/* File: mode_ctrl.sv */
// Purpose: Operating mode choice, debug entry and exit, command gating, pin ownership.
// Assumes: Memory read data arrive one cycle after mem_rd_o; por_flag_i is a same-clock level.
// Notes: The debug status byte is reached only through serial commands.
// Overview of operation
// - Debug pin high at reset release selects run mode.
// - Run start fetches a start address from two vector bytes, high first.
// - Debug pin low at power-up reset release enters debug; host holds it low.
// - The serial enter-debug command enters debug mode.
// - The halt-to-debug instruction enters debug mode.
// - A breakpoint hit enters debug mode.
// - In debug mode the processor stays halted and only serves commands.
// - Memory, status, debug register and enter-debug commands work in both modes.
// - Processor register and trace commands work only in debug mode.
// - The resume command leaves debug mode and resumes the program.
// - With debug disabled the debug pin is an output only.
// - Low frequency inputs work only while their enable bit is set.
// - Port B pins float whenever the low frequency receiver is enabled.
// - A port A pulldown acts only with that pin's wake-up enabled.
// - Port A pins drive keyboard interrupt bits of the same index.
// - Port A low pins feed the converter, high pins the timer inputs.
// - Debug status and control is not bus mapped, only serially reached.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module mode_ctrl
   import mode_debug_pkg::*;
#(
   parameter int ONE_MAX = ONE_LOW_MAX_CYC,
   parameter int IDLE_MAX = IDLE_CYC
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic por_flag_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Debug pin
   input wire logic dbg_pin_i,
   output logic dbg_pin_o,
   output logic dbg_pin_oe_o,
   // Processor side
   input wire logic halt_instr_i,
   input wire logic breakpoint_hit_i,
   input wire logic [7:0] mem_rdata_i,
   output logic [15:0] mem_addr_o,
   output logic mem_rd_o,
   output logic [15:0] start_pc_o,
   output logic cpu_start_o,
   output logic cpu_halt_o,
   output logic trace_step_o,
   // Command strobes
   output logic nonint_cmd_o,
   output logic active_cmd_o,
   output logic [7:0] cmd_code_o,
   output logic cmd_reject_o,
   output logic [7:0] status_o,
   output logic status_valid_o,
   // Port pins
   input wire logic [3:0] pa_i,
   input wire logic [1:0] pb_i,
   input wire logic lf_a_i,
   input wire logic lf_b_i,
   output logic [3:0] pa_o,
   output logic [3:0] pa_oe_o,
   output logic [3:0] pa_pu_o,
   output logic [3:0] pa_pd_o,
   output logic [3:0] kbi_o,
   output logic [1:0] adc_ch_o,
   output logic [1:0] tmr_ch_o,
   output logic [1:0] pb_o,
   output logic [1:0] pb_oe_o,
   output logic [1:0] pb_pu_o,
   output logic lf_a_o,
   output logic lf_b_o
);
   import mode_debug_pkg::*;

   function automatic logic is_nonint(input logic [7:0] code);
      is_nonint = (code == CMD_BACKGROUND) || (code == CMD_READ_STATUS) || (code == CMD_WRITE_CONTROL) ||
                  (code == CMD_READ_BYTE) || (code == CMD_READ_BYTE_WS) || (code == CMD_WRITE_BYTE) ||
                  (code == CMD_WRITE_BYTE_WS) || (code == CMD_READ_DREG) || (code == CMD_WRITE_DREG);
   endfunction : is_nonint

   function automatic logic is_active_only(input logic [7:0] code);
      is_active_only = (code == CMD_READ_CPU) || (code == CMD_WRITE_CPU) || (code == CMD_TRACE1) ||
                       (code == CMD_GO);
   endfunction : is_active_only

   rx_byte_if rx ();
   pin_cfg_if pcfg ();

   mode_state_type state_reg;
   mode_state_type state_next;
   logic pin_s1_reg;
   logic pin_s2_reg;
   logic [7:0] vec_hi_reg;
   logic dbg_enable_reg;
   logic wc_pending_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] porta_reg;
   logic [31:0] portb_reg;
   logic listen;
   logic in_debug;
   logic bg_cmd;
   logic go_cmd;
   logic enter_req;
   logic apb_wr;
   logic apb_setup;

   // The debug pin is asynchronous; its first stage feeds only the second.
   always_ff @(posedge core_clk_i) begin
      pin_s1_reg <= dbg_pin_i;
      pin_s2_reg <= pin_s1_reg;
   end

   assign in_debug = (state_reg == S_DEBUG);
   assign listen = dbg_enable_reg && (state_reg != S_DECIDE);
   assign bg_cmd = rx.valid && !wc_pending_reg && (rx.data == CMD_BACKGROUND);
   assign go_cmd = rx.valid && !wc_pending_reg && (rx.data == CMD_GO) && in_debug;
   assign enter_req = bg_cmd || halt_instr_i || breakpoint_hit_i;

   debug_rx #(
      .ONE_MAX(ONE_MAX),
      .IDLE_MAX(IDLE_MAX)
   ) u_rx (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_level_i(pin_s2_reg),
      .listen_i(listen),
      .rx(rx.src)
   );

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_DECIDE: begin
            state_next = (!pin_s2_reg && por_flag_i) ? S_DEBUG : S_FETCH_HI;
         end
         S_FETCH_HI: begin
            state_next = S_FETCH_LO;
         end
         S_FETCH_LO: begin
            state_next = S_LOAD;
         end
         S_LOAD: begin
            state_next = S_RUN;
         end
         S_RUN: begin
            if (enter_req) begin
               state_next = S_DEBUG;
            end
         end
         S_DEBUG: begin
            if (go_cmd) begin
               state_next = S_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= S_DECIDE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Vector fetch: address is out one cycle, its byte comes back the next.
   always_ff @(posedge core_clk_i) begin
      cpu_start_o <= 1'b0;
      if (sys_rst_i) begin
         mem_addr_o <= '0;
         mem_rd_o <= 1'b0;
         vec_hi_reg <= '0;
         start_pc_o <= '0;
      end else begin
         mem_rd_o <= 1'b0;
         if (state_reg == S_DECIDE && state_next == S_FETCH_HI) begin
            mem_addr_o <= RESET_VEC_HI_ADDR;
            mem_rd_o <= 1'b1;
         end
         if (state_reg == S_FETCH_HI) begin
            mem_addr_o <= RESET_VEC_LO_ADDR;
            mem_rd_o <= 1'b1;
         end
         if (state_reg == S_FETCH_LO) begin
            vec_hi_reg <= mem_rdata_i;
         end
         if (state_reg == S_LOAD) begin
            start_pc_o <= {vec_hi_reg, mem_rdata_i};
            cpu_start_o <= 1'b1;
         end
      end
   end

   // The processor runs only in run mode; fetch and debug both keep it halted.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cpu_halt_o <= 1'b1;
      end else begin
         cpu_halt_o <= (state_next != S_RUN);
      end
   end

   // Serial command gating; the status byte lives here and nowhere on the bus.
   always_ff @(posedge core_clk_i) begin
      nonint_cmd_o <= 1'b0;
      active_cmd_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      trace_step_o <= 1'b0;
      status_valid_o <= 1'b0;
      if (sys_rst_i) begin
         dbg_enable_reg <= DSC_RESET[DSC_ENABLE];
         wc_pending_reg <= 1'b0;
         cmd_code_o <= '0;
         status_o <= '0;
      end else if (rx.valid) begin
         cmd_code_o <= rx.data;
         if (wc_pending_reg) begin
            dbg_enable_reg <= rx.data[DSC_ENABLE];
            wc_pending_reg <= 1'b0;
         end else if (is_nonint(rx.data)) begin
            nonint_cmd_o <= 1'b1;
            if (rx.data == CMD_READ_STATUS) begin
               status_o <= DSC_RESET & {dbg_enable_reg, 7'h00} | {1'b0, in_debug, 6'h00};
               status_valid_o <= 1'b1;
            end
            if (rx.data == CMD_WRITE_CONTROL) begin
               wc_pending_reg <= 1'b1;
            end
         end else if (is_active_only(rx.data)) begin
            if (in_debug) begin
               active_cmd_o <= 1'b1;
               trace_step_o <= (rx.data == CMD_TRACE1);
            end else begin
               cmd_reject_o <= 1'b1;
            end
         end else begin
            cmd_reject_o <= 1'b1;
         end
      end
   end

   // With debug disabled the shared pin becomes a driven output and the receiver is deaf.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         dbg_pin_o <= 1'b0;
         dbg_pin_oe_o <= 1'b0;
      end else begin
         dbg_pin_o <= ctrl_reg[CTRL_PA4_OUT];
         dbg_pin_oe_o <= !dbg_enable_reg && (state_reg != S_DECIDE);
      end
   end

   // APB slave: zero wait states, read data registered in the setup cycle.
   assign apb_setup = psel_i && !penable_i;
   assign apb_wr = psel_i && penable_i && pwrite_i && pready_o;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= WORD_ZERO;
         porta_reg <= WORD_ZERO;
         portb_reg <= WORD_ZERO;
      end else if (apb_wr) begin
         unique case (paddr_i)
            ADDR_CTRL: ctrl_reg <= pwdata_i;
            ADDR_PORTA: porta_reg <= pwdata_i;
            ADDR_PORTB: portb_reg <= pwdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         prdata_o <= WORD_ZERO;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= apb_setup;
         pslverr_o <= 1'b0;
         if (apb_setup) begin
            prdata_o <= WORD_ZERO;
            unique case (paddr_i)
               ADDR_CTRL: prdata_o <= ctrl_reg & {30'h0, 2'h3};
               ADDR_PORTA: prdata_o <= porta_reg & {8'h00, 24'hff_ffff};
               ADDR_PORTB: prdata_o <= portb_reg & {26'h0, 6'h3f};
               ADDR_STATUS: begin
                  prdata_o[ST_DEBUG] <= in_debug;
                  prdata_o[ST_RUN] <= (state_reg == S_RUN);
                  prdata_o[ST_PA_LSB +: 4] <= pcfg.pa_in;
                  prdata_o[ST_PB_LSB +: 2] <= pcfg.pb_in;
               end
               default: pslverr_o <= 1'b1;
            endcase
         end
      end
   end

   assign pcfg.lf_en = ctrl_reg[CTRL_LF_EN];
   assign pcfg.pa_dir = porta_reg[PA_DIR_LSB +: 4];
   assign pcfg.pa_out = porta_reg[PA_OUT_LSB +: 4];
   assign pcfg.pa_pull_en = porta_reg[PA_PULL_EN_LSB +: 4];
   assign pcfg.pa_pull_dn = porta_reg[PA_PULL_DN_LSB +: 4];
   assign pcfg.pa_wake = porta_reg[PA_WAKE_LSB +: 4];
   assign pcfg.adc_sel = porta_reg[PA_ADC_LSB +: 2];
   assign pcfg.tmr_sel = porta_reg[PA_TMR_LSB +: 2];
   assign pcfg.pb_dir = portb_reg[PB_DIR_LSB +: 2];
   assign pcfg.pb_out = portb_reg[PB_OUT_LSB +: 2];
   assign pcfg.pb_pu = portb_reg[PB_PU_LSB +: 2];

   pin_mux u_pins (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .cfg(pcfg.mux),
      .pa_i(pa_i),
      .pb_i(pb_i),
      .lf_a_i(lf_a_i),
      .lf_b_i(lf_b_i),
      .pa_o(pa_o),
      .pa_oe_o(pa_oe_o),
      .pa_pu_o(pa_pu_o),
      .pa_pd_o(pa_pd_o),
      .kbi_o(kbi_o),
      .adc_ch_o(adc_ch_o),
      .tmr_ch_o(tmr_ch_o),
      .pb_o(pb_o),
      .pb_oe_o(pb_oe_o),
      .pb_pu_o(pb_pu_o),
      .lf_a_o(lf_a_o),
      .lf_b_o(lf_b_o)
   );
endmodule : mode_ctrl

/* File: dbg_host.sv */
// Purpose: Model of the external debug host on the single-wire pin.
// Assumes: The pin has a pull-up, so a released pin reads high.
// Notes: A short low is a one, a long low a zero, MSB first.
`timescale 1ns/1ps
module dbg_host (
   // Clock
   input wire logic core_clk_i,
   // Pin drive, high when released
   output logic pin_o
);
   initial pin_o = 1'b1;
   // Status and control are only reachable through these serial bytes.
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         pin_o <= 1'b0;
         repeat (b[i] ? 2 : 9) @(posedge core_clk_i);
         pin_o <= 1'b1;
         repeat (4) @(posedge core_clk_i);
      end
      repeat (8) @(posedge core_clk_i);
   endtask : send
   task automatic hold(input logic v);
      @(posedge core_clk_i);
      pin_o <= v;
   endtask : hold
endmodule : dbg_host

/* File: mode_ctrl_properties.sv */
// Purpose: Port-level checks for the mode and debug entry block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Pin inputs reach outputs after three edges.
`timescale 1ns/1ps
module mode_ctrl_checker
   import mode_debug_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Processor and commands
   input wire logic halt_instr_i,
   input wire logic breakpoint_hit_i,
   input wire logic cpu_halt_o,
   input wire logic cpu_start_o,
   input wire logic active_cmd_o,
   input wire logic nonint_cmd_o,
   input wire logic cmd_reject_o,
   input wire logic [7:0] cmd_code_o,
   // Pins
   input wire logic [3:0] pa_i,
   input wire logic lf_a_i,
   input wire logic lf_a_o,
   input wire logic [1:0] pb_oe_o,
   input wire logic [3:0] kbi_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_halt_entry: assert property (!cpu_halt_o && halt_instr_i |=> cpu_halt_o)
      else $error("halt not taken");
   a_brk_entry: assert property (!cpu_halt_o && breakpoint_hit_i |=> cpu_halt_o)
      else $error("breakpoint not taken");
   a_resume_cause: assert property ($fell(cpu_halt_o) |-> cpu_start_o || cmd_code_o == CMD_GO)
      else $error("processor resumed without cause");
   a_active_only: assert property (active_cmd_o |-> $past(cpu_halt_o))
      else $error("active command while running");
   a_reject_excl: assert property (cmd_reject_o |-> !active_cmd_o && !nonint_cmd_o)
      else $error("rejected command also executed");
   a_lf_float: assert property ($rose(lf_a_o) |-> pb_oe_o == 2'b00)
      else $error("port B driven with receiver on");
   a_lf_input: assert property (lf_a_o |-> $past(lf_a_i, 3))
      else $error("receiver input not from pin");
   a_kbi_map: assert property ((kbi_o & ~$past(pa_i, 3)) == 4'h0)
      else $error("keyboard bit without its pin");
   c_halt: cover property (halt_instr_i && !cpu_halt_o);
   c_active: cover property (active_cmd_o);
   c_reject: cover property (cmd_reject_o);
endmodule : mode_ctrl_checker
bind mode_ctrl mode_ctrl_checker u_chk (.core_clk_i, .sys_rst_i, .halt_instr_i, .breakpoint_hit_i,
   .cpu_halt_o, .cpu_start_o, .active_cmd_o, .nonint_cmd_o, .cmd_reject_o, .cmd_code_o, .pa_i,
   .lf_a_i, .lf_a_o, .pb_oe_o, .kbi_o);

/* File: operating_mode_and_debug_entry_tb.sv */
// Purpose: Self-checking bench for the mode and debug entry block.
// Assumes: Pin level is host and device drive wired-AND when enabled, else the host.
// Notes: Short serial limits keep the run brief.
`timescale 1ns/1ps
module operating_mode_and_debug_entry_tb;
   import mode_debug_pkg::*;
   logic core_clk_i = 0, sys_rst_i = 1, por_flag_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic halt_instr_i = 0, breakpoint_hit_i = 0, lf_a_i = 1, lf_b_i = 0, host_pin, e;
   logic pready_o, pslverr_o, dbg_pin_o, dbg_pin_oe_o, cpu_start_o, cpu_halt_o, lf_a_o;
   logic active_cmd_o, nonint_cmd_o, cmd_reject_o, trace_step_o;
   logic [11:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, r;
   logic [31:0] pw [3] = '{32'h0005_ff00, 32'h000a_ff00, 32'h00f0_0000};
   logic [15:0] mem_addr_o, start_pc_o;
   logic [7:0] mem_rdata_i = '0;
   logic [3:0] pa_i = 4'hf, pa_pd_o, kbi_o;
   logic [1:0] pb_i = 2'h2, pb_oe_o, adc_ch_o, tmr_ch_o;
   int num_errors = 0, n_checks = 0, n_rej = 0, n_act = 0, n_non = 0, n_st = 0, n_tr = 0;
   wire dbg_wire = host_pin & (dbg_pin_o | !dbg_pin_oe_o);
   always #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      mem_rdata_i <= mem_addr_o[0] ? 8'h34 : 8'h12;
      n_rej <= n_rej + cmd_reject_o;
      n_act <= n_act + active_cmd_o;
      n_non <= n_non + nonint_cmd_o;
      n_st <= n_st + cpu_start_o;
      n_tr <= n_tr + trace_step_o;
   end
   mode_ctrl #(.ONE_MAX(4), .IDLE_MAX(32)) DUT (.core_clk_i, .sys_rst_i, .por_flag_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .dbg_pin_i(dbg_wire), .dbg_pin_o, .dbg_pin_oe_o, .halt_instr_i, .breakpoint_hit_i, .mem_rdata_i,
      .mem_addr_o, .mem_rd_o(), .start_pc_o, .cpu_start_o, .cpu_halt_o, .trace_step_o, .nonint_cmd_o,
      .active_cmd_o, .cmd_code_o(), .cmd_reject_o, .status_o(), .status_valid_o(), .pa_i, .pb_i,
      .lf_a_i, .lf_b_i, .pa_o(), .pa_oe_o(), .pa_pu_o(), .pa_pd_o, .kbi_o, .adc_ch_o, .tmr_ch_o,
      .pb_o(), .pb_oe_o, .pb_pu_o(), .lf_a_o, .lf_b_o());
   dbg_host host (.core_clk_i, .pin_o(host_pin));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      n_checks++;
      if (s !== x) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1;
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge core_clk_i);
   endtask : apb
   task automatic stop_cpu(input logic b);
      halt_instr_i <= !b;
      breakpoint_hit_i <= b;
      @(posedge core_clk_i);
      halt_instr_i <= 0;
      breakpoint_hit_i <= 0;
      repeat (2) @(posedge core_clk_i);
      chk("halt", 1, cpu_halt_o);
      host.send(CMD_GO);
      chk("resume", 0, cpu_halt_o);
   endtask : stop_cpu
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge core_clk_i);
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge core_clk_i);
      sys_rst_i <= 0;
      repeat (8) @(posedge core_clk_i);
      chk("start_pc", 32'h1234, start_pc_o);
      chk("run", 0, cpu_halt_o);
      host.send(CMD_TRACE1);
      chk("reject", 1, n_rej);
      host.send(CMD_BACKGROUND);
      chk("enter", 1, cpu_halt_o);
      host.send(CMD_BACKGROUND);
      host.send(CMD_READ_CPU);
      host.send(CMD_TRACE1);
      chk("nonint", 2, n_non);
      chk("active", 2, n_act);
      chk("trace", 1, n_tr);
      chk("halted", 1, cpu_halt_o);
      host.send(CMD_GO);
      chk("go", 0, cpu_halt_o);
      chk("refetch", 1, n_st);
      stop_cpu(0);
      stop_cpu(1);
      apb(1, ADDR_PORTB, 32'h0000_0003);
      for (int i = 0; i < 2; i++) begin
         apb(1, ADDR_CTRL, i);
         repeat (4) @(posedge core_clk_i);
         chk("pb_oe", i ? 0 : 3, pb_oe_o);
         chk("lf_a", i, lf_a_o);
      end
      foreach (pw[k]) begin
         apb(1, ADDR_PORTA, pw[k]);
         repeat (2) @(posedge core_clk_i);
         chk("pull_dn", pw[k][19:16], pa_pd_o);
         chk("kbi", pw[k][19:16], kbi_o);
         chk("adc_tmr", pw[k][23:20], {tmr_ch_o, adc_ch_o});
      end
      apb(0, ADDR_STATUS, 0);
      chk("status", 32'h0000_00be, r);
      apb(0, 12'h010, 0);
      chk("unmapped", 32'h0000_0001, {r[30:0], e});
      apb(1, ADDR_CTRL, 2);
      host.send(CMD_WRITE_CONTROL);
      host.send(8'h00);
      chk("pin_out", 1, dbg_pin_oe_o);
      chk("pin_val", 1, dbg_pin_o);
      host.send(CMD_BACKGROUND);
      chk("no_input", 0, cpu_halt_o);
      for (int p = 0; p < 2; p++) begin
         sys_rst_i <= 1;
         por_flag_i <= p[0];
         host.hold(0);
         repeat (6) @(posedge core_clk_i);
         sys_rst_i <= 0;
         repeat (8) @(posedge core_clk_i);
         chk("boot_halt", p, cpu_halt_o);
      end
      host.hold(1);
      repeat (10) @(posedge core_clk_i);
      chk("dbg_boot", 1, cpu_halt_o);
      chk("no_fetch", 2, n_st);
      report_and_stop();
   end
endmodule : operating_mode_and_debug_entry_tb
